// ### ogc_pkg.sv
// Shared constants, types and arithmetic for the offset/gain calibration
// unit. Assumes both ends run on clk_sys and see the same map.
package ogc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_OFS_LO  = 8'h07;
  localparam logic [7:0] ADDR_OFS_MID = 8'h08;
  localparam logic [7:0] ADDR_OFS_HI  = 8'h09;
  localparam logic [7:0] ADDR_GAIN_LO  = 8'h0a;
  localparam logic [7:0] ADDR_GAIN_MID = 8'h0b;
  localparam logic [7:0] ADDR_GAIN_HI  = 8'h0c;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Word values
  localparam logic [23:0] OFFSET_RESET  = 24'h000000;
  localparam logic [23:0] GAIN_UNITY    = 24'h400000;
  localparam logic [23:0] GAIN_REDUCED  = 24'h03cccc;
  localparam logic [23:0] CODE_POS_FS   = 24'h7fffff;
  localparam logic [23:0] CODE_NEG_FS   = 24'h800000;
  localparam logic [23:0] CODE_EXPECTED = 24'h799998;
  localparam logic [23:0] GAIN_MAX      = 24'hffffff;
  localparam logic [21:0] UNITY_ZEROS   = 22'h000000;

  // Arithmetic layout
  localparam int         GAIN_SHIFT    = 22;
  localparam int         AVG_SHIFT     = 4;
  localparam logic [4:0] CAL_AVG_COUNT = 5'h10;
  localparam logic [4:0] CNT_STEP      = 5'h01;
  localparam logic [1:0] BYTE_LAST     = 2'h2;

  typedef enum logic [1:0] {
    OGC_OP_WRITE,
    OGC_OP_READ,
    OGC_OP_OFFSET_CAL,
    OGC_OP_GAIN_CAL
  } ogc_cmd_e;

  typedef enum logic [2:0] {
    OGC_REQ_WRITE,
    OGC_REQ_READ,
    OGC_REQ_OFFSET_CAL,
    OGC_REQ_GAIN_CAL,
    OGC_REQ_USER_OFFSET,
    OGC_REQ_USER_GAIN
  } ogc_req_e;

  // Byte idx (0 low .. 2 high) of a 24-bit word
  function automatic logic [7:0] ogc_byte(input logic [23:0] w,
                                          input logic [1:0]  idx);
    ogc_byte = (idx == 2'h0) ? w[7:0] : (idx == 2'h1) ? w[15:8] : w[23:16];
  endfunction

  // Restoring division, saturating at 24 bits; zero divisor gives max
  function automatic logic [23:0] ogc_div_sat(input logic [45:0] num,
                                              input logic [23:0] den);
    logic [45:0] q;
    logic [24:0] r;
    q = '0;
    r = '0;
    for (int i = 45; i >= 0; i--) begin
      r = {r[23:0], num[i]};
      if (r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        q[i] = 1'b1;
      end
    end
    if (den == 24'h000000 || q[45:24] != 22'h000000)
      ogc_div_sat = GAIN_MAX;
    else
      ogc_div_sat = q[23:0];
  endfunction

endpackage

// ### ogc_link_if.sv
// Command link between the converter's calibration unit and its host.
// Assumes both parties share clk_sys; the serial framing is abstracted.
`timescale 1ns/1ps
interface ogc_link_if;
  logic               converter_select_n;
  logic               start;
  logic               reg_unlocked;
  logic               cmd_valid;
  ogc_pkg::ogc_cmd_e  cmd_op;
  logic [7:0]         cmd_addr;
  logic [7:0]         cmd_wdata;
  logic               conversion_ready_n;
  logic [7:0]         rd_data;
  logic               rd_valid;
  logic [23:0]        result_data;
  logic               result_strobe;

  modport device (
    input  converter_select_n, start, reg_unlocked, cmd_valid, cmd_op,
    input  cmd_addr, cmd_wdata,
    output conversion_ready_n, rd_data, rd_valid, result_data,
    output result_strobe
  );
  modport host (
    output converter_select_n, start, reg_unlocked, cmd_valid, cmd_op,
    output cmd_addr, cmd_wdata,
    input  conversion_ready_n, rd_data, rd_valid, result_data,
    input  result_strobe
  );
endinterface

// ### ogc_device.sv
// Converter end: calibration registers, result correction and the
// command-driven offset and gain calibrations.
// Assumes raw conversions arrive as one-cycle strobes on clk_sys.
//
// Behaviour
// RULE1: Offset word in bytes 07h, 08h, 09h.
// RULE2: Offset is signed, subtracted from each result.
// RULE3: Zero offset leaves the result unchanged.
// RULE4: Gain word in bytes 0Ah, 0Bh, 0Ch.
// RULE5: Gain unsigned, 400000h means unity.
// RULE6: Host keeps input within 106 percent range.
// RULE7: Offset command averages 16 results, stores offset.
// RULE8: One conversion follows using new offset.
// RULE9: Gain command averages 16, maps to full scale.
// RULE10: Host unlocks registers before calibration commands.
// RULE11: Host starts conversions, then sends command promptly.
// RULE12: Data ready driven high when calibration starts.
// RULE13: Select high cancels calibration in progress.
// RULE14: Host sends nothing else during calibration.
// RULE15: At completion ready low, registers updated.
// RULE16: Duration follows data rate and filter.
// RULE17: Host calibrates offset before gain.
// RULE18: Host presets offset zero, gain unity first.
// RULE19: Host user offset: average shorted results, write.
// RULE20: Host user gain: reduced gain, average, divide.
// RULE21: Output is (raw minus offset) times gain/400000h.
// RULE22: Corrected result saturates to 24 bits.
// RULE23: Stored offset nulls a shorted input.
`timescale 1ns/1ps
module ogc_device (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  ogc_link_if.device       link,
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  output logic      [23:0] corr_data,
  output logic             corr_valid,
  output logic             cal_busy,
  output logic      [23:0] offset_word,
  output logic      [23:0] gain_word
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCUM,
    ST_FINAL
  } ogc_cal_state_e;

  // Signed correction with clipping to the 24-bit code range
  function automatic logic [23:0] ogc_correct(input logic [23:0] raw,
                                              input logic [23:0] ofs,
                                              input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [50:0] prod;
    logic signed [50:0] scaled;
    diff   = $signed({raw[23], raw}) - $signed({ofs[23], ofs}); // [RULE2]
    prod   = diff * $signed({1'b0, gain});                      // [RULE5]
    scaled = prod >>> ogc_pkg::GAIN_SHIFT;                      // [RULE21]
    if (scaled > $signed({27'h0000000, ogc_pkg::CODE_POS_FS}))
      ogc_correct = ogc_pkg::CODE_POS_FS;                       // [RULE22]
    else if (scaled < $signed({27'h7ffffff, ogc_pkg::CODE_NEG_FS}))
      ogc_correct = ogc_pkg::CODE_NEG_FS;                       // [RULE22]
    else
      ogc_correct = scaled[23:0];
  endfunction

  ogc_cal_state_e state_reg;
  ogc_cal_state_e state_next;
  logic        cal_gain_reg;
  logic [4:0]  cnt_reg;
  logic [28:0] sum_reg;
  logic [23:0] offset_word_reg;
  logic [23:0] offset_word_next;
  logic [23:0] gain_word_reg;
  logic [23:0] gain_word_next;
  logic [23:0] corr_data_reg;
  logic        corr_valid_reg;
  logic        ready_n_reg;
  logic        ready_n_next;
  logic [7:0]  rd_data_reg;
  logic        rd_valid_reg;
  logic        start_d_reg;

  // Command decode; commands count only while the select is low
  wire cmd_take   = link.cmd_valid & ~link.converter_select_n;
  wire is_idle    = (state_reg == ST_IDLE);
  wire wr_take    = cmd_take & (link.cmd_op == ogc_pkg::OGC_OP_WRITE) &
                    is_idle;
  wire rd_take    = cmd_take & (link.cmd_op == ogc_pkg::OGC_OP_READ);
  wire ofs_cmd    = link.cmd_op == ogc_pkg::OGC_OP_OFFSET_CAL;
  wire gain_cmd   = link.cmd_op == ogc_pkg::OGC_OP_GAIN_CAL;
  // Locked registers or stopped conversions make the command a no-op
  wire cal_take   = cmd_take & (ofs_cmd | gain_cmd) & is_idle &
                    link.reg_unlocked & link.start;
  wire cancel     = ~is_idle & link.converter_select_n;   // [RULE13]
  wire start_rise = link.start & ~start_d_reg;

  // Averaging path; gain calibration averages offset-corrected samples
  wire [24:0] raw_ext  = {raw_data[23], raw_data};
  wire [24:0] raw_diff = raw_ext - {offset_word_reg[23], offset_word_reg};
  wire [24:0] sample   = cal_gain_reg ? raw_diff : raw_ext;
  wire [28:0] sum_new  = sum_reg + {{4{sample[24]}}, sample};
  wire [24:0] avg      = sum_new[28:ogc_pkg::AVG_SHIFT];
  wire        acc_hit  = raw_valid & (state_reg == ST_ACCUM) & ~cancel;
  wire        acc_last = acc_hit &
                         (cnt_reg == ogc_pkg::CAL_AVG_COUNT - ogc_pkg::CNT_STEP);
  // Non-positive average cannot be scaled up; clamp to the largest gain
  wire [23:0] gain_cal = (avg[24] | (avg == 25'h0000000)) ?
                         ogc_pkg::GAIN_MAX :
                         ogc_pkg::ogc_div_sat({ogc_pkg::CODE_POS_FS,
                                               ogc_pkg::UNITY_ZEROS},
                                              avg[23:0]);       // [RULE9]
  wire store_ofs  = acc_last & ~cal_gain_reg;                  // [RULE7]
  wire store_gain = acc_last & cal_gain_reg;                   // [RULE9]

  // Results leave the block except while samples are being averaged
  wire        pass_out = raw_valid & (state_reg != ST_ACCUM);
  wire [23:0] corr_now = ogc_correct(raw_data, offset_word_reg,
                                     gain_word_reg);

  // Register read mux, unmapped addresses read zero
  wire [7:0] rd_mux =
    (link.cmd_addr == ogc_pkg::ADDR_OFS_LO)   ? offset_word_reg[7:0]   :
    (link.cmd_addr == ogc_pkg::ADDR_OFS_MID)  ? offset_word_reg[15:8]  :
    (link.cmd_addr == ogc_pkg::ADDR_OFS_HI)   ? offset_word_reg[23:16] :
    (link.cmd_addr == ogc_pkg::ADDR_GAIN_LO)  ? gain_word_reg[7:0]     :
    (link.cmd_addr == ogc_pkg::ADDR_GAIN_MID) ? gain_word_reg[15:8]    :
    (link.cmd_addr == ogc_pkg::ADDR_GAIN_HI)  ? gain_word_reg[23:16]   :
    ogc_pkg::READ_UNMAPPED;

  // Calibration store beats a host write in the same cycle
  always_comb begin
    offset_word_next = offset_word_reg;
    gain_word_next   = gain_word_reg;
    if (store_ofs) begin
      offset_word_next = avg[23:0];                            // [RULE23]
    end else if (store_gain) begin
      gain_word_next = gain_cal;
    end else if (wr_take) begin
      if (link.cmd_addr == ogc_pkg::ADDR_OFS_LO) begin
        offset_word_next[7:0] = link.cmd_wdata;                // [RULE1]
      end else if (link.cmd_addr == ogc_pkg::ADDR_OFS_MID) begin
        offset_word_next[15:8] = link.cmd_wdata;               // [RULE1]
      end else if (link.cmd_addr == ogc_pkg::ADDR_OFS_HI) begin
        offset_word_next[23:16] = link.cmd_wdata;              // [RULE1]
      end else if (link.cmd_addr == ogc_pkg::ADDR_GAIN_LO) begin
        gain_word_next[7:0] = link.cmd_wdata;                  // [RULE4]
      end else if (link.cmd_addr == ogc_pkg::ADDR_GAIN_MID) begin
        gain_word_next[15:8] = link.cmd_wdata;                 // [RULE4]
      end else if (link.cmd_addr == ogc_pkg::ADDR_GAIN_HI) begin
        gain_word_next[23:16] = link.cmd_wdata;                // [RULE4]
      end
    end
  end

  // Calibration sequence: average, store, then one fresh conversion
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cal_take)
          state_next = ST_ACCUM;
      end
      ST_ACCUM: begin
        if (cancel)
          state_next = ST_IDLE;
        else if (acc_last)
          state_next = ST_FINAL;     // Paced by conversions [RULE16]
      end
      ST_FINAL: begin
        if (cancel || raw_valid)
          state_next = ST_IDLE;      // [RULE8]
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Ready is high from a start until the next delivered result
  always_comb begin
    ready_n_next = ready_n_reg;
    if (cal_take || start_rise)
      ready_n_next = 1'b1;           // [RULE12]
    else if (pass_out)
      ready_n_next = 1'b0;           // [RULE15]
  end

  // Word registers and sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg       <= ST_IDLE;
      offset_word_reg <= ogc_pkg::OFFSET_RESET;
      gain_word_reg   <= ogc_pkg::GAIN_UNITY;
      ready_n_reg     <= 1'b1;
      start_d_reg     <= 1'b0;
    end else begin
      state_reg       <= state_next;
      offset_word_reg <= offset_word_next;
      gain_word_reg   <= gain_word_next;
      ready_n_reg     <= ready_n_next;
      start_d_reg     <= link.start;
    end
  end

  // Accumulator; cleared when a calibration is accepted
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cal_gain_reg <= 1'b0;
      cnt_reg      <= 5'h00;
      sum_reg      <= 29'h00000000;
    end else if (cal_take) begin
      cal_gain_reg <= gain_cmd;
      cnt_reg      <= 5'h00;
      sum_reg      <= 29'h00000000;
    end else if (acc_hit) begin
      cnt_reg <= cnt_reg + ogc_pkg::CNT_STEP;                  // [RULE7]
      sum_reg <= sum_new;
    end
  end

  // Output registers; the result uses the word valid at sample time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      corr_data_reg  <= 24'h000000;
      corr_valid_reg <= 1'b0;
      rd_data_reg    <= 8'h00;
      rd_valid_reg   <= 1'b0;
    end else begin
      corr_valid_reg <= pass_out;
      rd_valid_reg   <= rd_take;
      if (pass_out)
        corr_data_reg <= corr_now;                             // [RULE3]
      if (rd_take)
        rd_data_reg <= rd_mux;
    end
  end

  assign corr_data               = corr_data_reg;
  assign corr_valid              = corr_valid_reg;
  assign cal_busy                = ~is_idle;
  assign offset_word             = offset_word_reg;
  assign gain_word               = gain_word_reg;
  assign link.conversion_ready_n = ready_n_reg;
  assign link.rd_data            = rd_data_reg;
  assign link.rd_valid           = rd_valid_reg;
  assign link.result_data        = corr_data_reg;
  assign link.result_strobe      = corr_valid_reg;

endmodule

// ### ogc_host.sv
// Host end: forwards register accesses, runs the command calibration
// handshake and the host-computed user calibration flows.
// Assumes the device end shares clk_sys; req_ready is combinational.
`timescale 1ns/1ps
module ogc_host (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  ogc_link_if.host               link,
  input  wire logic              req_valid,
  input  wire ogc_pkg::ogc_req_e req_op,
  input  wire logic [7:0]        req_addr,
  input  wire logic [7:0]        req_wdata,
  output logic                   req_ready,
  input  wire logic              start_conv,
  input  wire logic              unlock,
  output logic [7:0]             rd_data,
  output logic                   rd_valid,
  output logic [23:0]            result_data,
  output logic                   result_valid,
  output logic                   busy
);

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_CAL,
    HS_WR,
    HS_ACC
  } ogc_host_state_e;

  ogc_host_state_e state_reg;
  logic              sel_n_reg;
  logic              start_reg;
  logic              unlock_reg;
  logic              cmd_valid_reg;
  ogc_pkg::ogc_cmd_e cmd_op_reg;
  logic [7:0]        cmd_addr_reg;
  logic [7:0]        cmd_wdata_reg;
  logic              sent_reg;
  logic              seen_high_reg;
  logic              user_gain_reg;
  logic [1:0]        step_reg;
  logic [1:0]        idx_reg;
  logic [7:0]        base_reg;
  logic [23:0]       word_reg;
  logic [4:0]        cnt_reg;
  logic [28:0]       sum_reg;
  logic [7:0]        rd_data_reg;
  logic              rd_valid_reg;
  logic [23:0]       res_data_reg;
  logic              res_valid_reg;

  // Averaging of returned results for the user flows
  wire [28:0] sum_new  = sum_reg + {{5{link.result_data[23]}},
                                    link.result_data};
  wire [24:0] avg      = sum_new[28:ogc_pkg::AVG_SHIFT];
  wire        acc_last = link.result_strobe &
                         (cnt_reg == ogc_pkg::CAL_AVG_COUNT - ogc_pkg::CNT_STEP);
  wire [23:0] gain_new = (avg[24] | (avg == 25'h0000000)) ?
                         ogc_pkg::GAIN_MAX :
                         ogc_pkg::ogc_div_sat({ogc_pkg::CODE_EXPECTED,
                                               ogc_pkg::UNITY_ZEROS},
                                              avg[23:0]);       // [RULE20]
  wire        wr_done  = (state_reg == HS_WR) &
                         (idx_reg == ogc_pkg::BYTE_LAST);
  wire        cal_done = sent_reg & seen_high_reg &
                         ~link.conversion_ready_n;
  wire        req_cal  = (req_op == ogc_pkg::OGC_REQ_OFFSET_CAL) |
                         (req_op == ogc_pkg::OGC_REQ_GAIN_CAL);

  // New requests only between operations [RULE14]
  assign req_ready = (state_reg == HS_IDLE);

  // Main sequencer; link command fields are registered
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg     <= HS_IDLE;
      sel_n_reg     <= 1'b1;
      start_reg     <= 1'b0;
      unlock_reg    <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_op_reg    <= ogc_pkg::OGC_OP_WRITE;
      cmd_addr_reg  <= 8'h00;
      cmd_wdata_reg <= 8'h00;
      sent_reg      <= 1'b0;
      seen_high_reg <= 1'b0;
      user_gain_reg <= 1'b0;
      step_reg      <= 2'h0;
      idx_reg       <= 2'h0;
      base_reg      <= 8'h00;
      word_reg      <= 24'h000000;
      cnt_reg       <= 5'h00;
      sum_reg       <= 29'h00000000;
    end else begin
      cmd_valid_reg <= 1'b0;
      unlock_reg    <= unlock;
      case (state_reg)
        HS_IDLE: begin
          sel_n_reg <= 1'b1;
          start_reg <= start_conv;
          if (req_valid && req_cal) begin
            state_reg     <= HS_CAL;
            start_reg     <= 1'b1;        // Start first [RULE11]
            sel_n_reg     <= 1'b0;        // [RULE13]
            sent_reg      <= 1'b0;
            seen_high_reg <= 1'b0;
            cmd_op_reg    <= (req_op == ogc_pkg::OGC_REQ_GAIN_CAL) ?
                             ogc_pkg::OGC_OP_GAIN_CAL :
                             ogc_pkg::OGC_OP_OFFSET_CAL;
          end else if (req_valid && (req_op == ogc_pkg::OGC_REQ_USER_OFFSET ||
                                     req_op == ogc_pkg::OGC_REQ_USER_GAIN)) begin
            state_reg     <= HS_WR;
            start_reg     <= 1'b1;
            user_gain_reg <= (req_op == ogc_pkg::OGC_REQ_USER_GAIN);
            step_reg      <= 2'h0;
            idx_reg       <= 2'h0;
            if (req_op == ogc_pkg::OGC_REQ_USER_GAIN) begin
              base_reg <= ogc_pkg::ADDR_GAIN_LO;
              word_reg <= ogc_pkg::GAIN_REDUCED;        // [RULE20]
            end else begin
              base_reg <= ogc_pkg::ADDR_OFS_LO;
              word_reg <= ogc_pkg::OFFSET_RESET;        // [RULE18]
            end
          end else if (req_valid) begin
            cmd_valid_reg <= 1'b1;
            sel_n_reg     <= 1'b0;
            cmd_op_reg    <= (req_op == ogc_pkg::OGC_REQ_READ) ?
                             ogc_pkg::OGC_OP_READ : ogc_pkg::OGC_OP_WRITE;
            cmd_addr_reg  <= req_addr;
            cmd_wdata_reg <= req_wdata;
          end
        end
        HS_CAL: begin
          // Unlocked input is the caller's duty; start is already high
          if (!sent_reg) begin
            cmd_valid_reg <= 1'b1;                      // [RULE10]
            sent_reg      <= 1'b1;
          end else if (link.conversion_ready_n) begin
            seen_high_reg <= 1'b1;
          end
          if (cal_done) begin
            state_reg <= HS_IDLE;       // Offset first is caller's [RULE17]
            sel_n_reg <= 1'b1;
          end
        end
        HS_WR: begin
          sel_n_reg     <= 1'b0;
          cmd_valid_reg <= 1'b1;
          cmd_op_reg    <= ogc_pkg::OGC_OP_WRITE;
          cmd_addr_reg  <= base_reg + {6'h00, idx_reg};
          cmd_wdata_reg <= ogc_pkg::ogc_byte(word_reg, idx_reg);
          idx_reg       <= idx_reg + 2'h1;
          if (wr_done) begin
            idx_reg  <= 2'h0;
            step_reg <= step_reg + 2'h1;
            cnt_reg  <= 5'h00;
            sum_reg  <= 29'h00000000;
            if (!user_gain_reg && step_reg == 2'h0) begin
              base_reg <= ogc_pkg::ADDR_GAIN_LO;
              word_reg <= ogc_pkg::GAIN_UNITY;          // [RULE18]
            end else if ((!user_gain_reg && step_reg == 2'h1) ||
                         (user_gain_reg && step_reg == 2'h0)) begin
              state_reg <= HS_ACC;
            end else begin
              state_reg <= HS_IDLE;
            end
          end
        end
        HS_ACC: begin
          sel_n_reg <= 1'b1;
          if (link.result_strobe) begin
            cnt_reg <= cnt_reg + ogc_pkg::CNT_STEP;
            sum_reg <= sum_new;
          end
          if (acc_last) begin
            state_reg <= HS_WR;
            step_reg  <= step_reg + 2'h1;
            if (user_gain_reg) begin
              base_reg <= ogc_pkg::ADDR_GAIN_LO;
              word_reg <= gain_new;
            end else begin
              base_reg <= ogc_pkg::ADDR_OFS_LO;
              word_reg <= avg[23:0];                    // [RULE19]
            end
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // Returned data towards the user side
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_reg   <= 8'h00;
      rd_valid_reg  <= 1'b0;
      res_data_reg  <= 24'h000000;
      res_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg  <= link.rd_valid;
      res_valid_reg <= link.result_strobe;
      if (link.rd_valid)
        rd_data_reg <= link.rd_data;
      if (link.result_strobe)
        res_data_reg <= link.result_data;   // Range kept by caller [RULE6]
    end
  end

  assign link.converter_select_n = sel_n_reg;
  assign link.start              = start_reg;
  assign link.reg_unlocked       = unlock_reg;
  assign link.cmd_valid          = cmd_valid_reg;
  assign link.cmd_op             = cmd_op_reg;
  assign link.cmd_addr           = cmd_addr_reg;
  assign link.cmd_wdata          = cmd_wdata_reg;
  assign rd_data                 = rd_data_reg;
  assign rd_valid                = rd_valid_reg;
  assign result_data             = res_data_reg;
  assign result_valid            = res_valid_reg;
  assign busy                    = (state_reg != HS_IDLE);

endmodule

// ### ogc_link_asserts.sv
// Concurrent checks on the link between converter end and host end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ogc_link_asserts (
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic              converter_select_n,
  input wire logic              start,
  input wire logic              cmd_valid,
  input wire ogc_pkg::ogc_cmd_e cmd_op,
  input wire logic [7:0]        cmd_addr,
  input wire logic              conversion_ready_n,
  input wire logic [7:0]        rd_data,
  input wire logic              rd_valid,
  input wire logic              result_strobe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Command decodes; both calibration codes have the upper op bit set
  wire rd_cmd = cmd_valid && !converter_select_n && cmd_op == 2'h1;
  wire cal_cmd = cmd_valid && cmd_op[1];
  wire unmapped = cmd_addr < 8'h07 || cmd_addr > 8'h0c;
  chk_read_answer: assert property (rd_cmd |=> rd_valid)
    else $error("read not answered");
  chk_read_cause: assert property (rd_valid |-> $past(rd_cmd))
    else $error("stray read data");
  chk_unmapped_zero: assert property (rd_cmd && unmapped |=> !rd_data)
    else $error("unmapped read not zero");
  chk_rd_hold: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read data moved");
  chk_cal_ready: assert property (cal_cmd |=> conversion_ready_n)
    else $error("ready not high on calibration");
  chk_strobe_ready: assert property (result_strobe |-> !conversion_ready_n)
    else $error("result without ready");
  chk_ready_fall: assert property ($fell(conversion_ready_n) |-> result_strobe)
    else $error("ready fell without result");
  chk_cal_select: assert property (cal_cmd |-> start && !converter_select_n)
    else $error("calibration sent unselected");
  // Main scenarios
  cover property (rd_valid && rd_data == 8'h00);
  cover property (cal_cmd && cmd_op == ogc_pkg::OGC_OP_GAIN_CAL);
  cover property ($fell(conversion_ready_n));
endmodule

// ### tb_adc_offset_gain_calibration.sv
// Self-checking bench joining device and host ends over the link.
// Assumes the shared package and interface are compiled first.
`timescale 1ns/1ps
module tb_adc_offset_gain_calibration;
  logic              clk_sys = 1'b0, sys_rst = 1'b1, raw_valid = 1'b0;
  logic              req_valid = 1'b0, start_conv = 1'b1, unlock = 1'b1;
  logic [23:0]       raw_data = '0, corr_data, offset_word, gain_word, r, w;
  logic [23:0]       o = '0, g = 24'h400000;
  logic [7:0]        req_addr = '0, req_wdata = '0, rd_data, b [6];
  ogc_pkg::ogc_req_e req_op = ogc_pkg::OGC_REQ_WRITE;
  logic              corr_valid, cal_busy, req_ready, rd_valid;
  logic [63:0]       q;
  int                err_count = 0, check_count = 0, s, n, t;
  ogc_link_if link ();
  ogc_device ogc_device_inst (.clk_sys, .sys_rst, .link(link.device),
    .raw_valid, .raw_data, .corr_data, .corr_valid, .cal_busy,
    .offset_word, .gain_word);
  ogc_host ogc_host_inst (.clk_sys, .sys_rst, .link(link.host), .req_valid,
    .req_op, .req_addr, .req_wdata, .req_ready, .start_conv, .unlock,
    .rd_data, .rd_valid, .result_data(), .result_valid(), .busy());
  ogc_link_asserts ogc_link_asserts_inst (.clk_sys, .sys_rst,
    .converter_select_n(link.converter_select_n), .start(link.start),
    .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op),
    .cmd_addr(link.cmd_addr), .conversion_ready_n(link.conversion_ready_n),
    .rd_data(link.rd_data), .rd_valid(link.rd_valid),
    .result_strobe(link.result_strobe));
  // 125 MHz clock
  initial forever #4 clk_sys = ~clk_sys;
  // Comparison, verdict, bounded wait and drivers
  task automatic chk(string nm, logic [23:0] seen, logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wt(ref logic sg);
    for (n = 0; n < 300 && sg !== 1'b1; n++) @(posedge clk_sys) #1;
    if (sg !== 1'b1) begin
      err_count++;
      results();
    end
  endtask
  task automatic req(ogc_pkg::ogc_req_e op, logic [7:0] a);
    @(posedge clk_sys) #1;
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_wdata = 8'($urandom);
    wt(req_ready);
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
  endtask
  task automatic conv(logic [23:0] d);
    @(posedge clk_sys) #1;
    raw_valid = 1'b1;
    raw_data = d;
    @(posedge clk_sys) #1;
    raw_valid = 1'b0;
  endtask
  // Corrected code: signed difference times gain, floor shift, clip
  function automatic logic [23:0] ex(logic [23:0] x, o, g);
    logic signed [49:0] p;
    p = ($signed({x[23], x}) - $signed({o[23], o})) * $signed({1'b0, g});
    p = p >>> 22;
    return p > 50'sh7fffff ? 24'h7fffff : p < -50'sh800000 ? 24'h800000
         : p[23:0];
  endfunction
  // Main sequence
  initial begin
    void'($urandom(2));
    repeat (20) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk("offset_word", offset_word, 24'h000000);
    chk("gain_word", gain_word, ogc_pkg::GAIN_UNITY);
    repeat (2) @(posedge clk_sys); // Let the start edge pass
    for (s = 0; s < 18; s++) begin
      if (s == 4) for (t = 0; t < 6; t++) begin
        req(ogc_pkg::OGC_REQ_WRITE, 8'h07 + 8'(t));
        b[t] = req_wdata;
        {g, o} = {b[5], b[4], b[3], b[2], b[1], b[0]};
      end
      r = 24'($urandom);
      conv(r);
      chk("corr", corr_data, ex(r, o, g));
    end
    for (s = 0; s < 7; s++) begin
      req(ogc_pkg::OGC_REQ_READ, 8'h07 + 8'(s));
      wt(rd_valid);
      chk("read", {16'h0, rd_data}, s < 6 ? {16'h0, b[s]} : 24'h0);
    end
    chk("offset_word", offset_word, o);
    chk("gain_word", gain_word, g);
    for (s = 0; s < 2; s++) begin
      req(s ? ogc_pkg::OGC_REQ_GAIN_CAL : ogc_pkg::OGC_REQ_OFFSET_CAL, 8'h0);
      wt(cal_busy);
      chk("ready_n", 24'(link.conversion_ready_n), 24'h1);
      t = 0;
      for (n = 0; n < 16; n++) begin
        r = s ? 24'h300000 + 24'($urandom % 4096) : 24'($signed(8'($urandom)));
        t += s ? $signed(r) - $signed(w) : $signed(r);
        conv(r);
      end
      q = (64'h7fffff << 22) / 64'(t >>> 4);
      if (s) g = q > 64'hffffff ? 24'hffffff : q[23:0];
      else w = 24'(t >>> 4);
      chk("cal", s ? gain_word : offset_word, s ? g : w);
      conv(r);
      chk("cal result", corr_data, ex(r, w, g));
      chk("ready", {corr_valid, cal_busy, link.conversion_ready_n}, 3'h4);
    end
    results();
  end
endmodule
